/* File: shared/cgc_pkg.sv */
// Constants, command codes and configuration carriers of the global
// command and reset block of the eight-channel codec.
// Assumes a 25 MHz system clock and byte-wide command delivery.
package cgc_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned RST_LOW_MIN_NS = 50000;
  localparam int unsigned RST_LOW_CYC    =
    (RST_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 11;
  localparam logic [CNT_W-1:0] RST_LOW_LAST = CNT_W'(RST_LOW_CYC - 1);

  localparam int unsigned N_CHAN  = 8;
  localparam int unsigned SLOT_W  = 7;
  localparam int unsigned RW_BIT  = 7;

  // Command codes with the read/write bit removed.
  localparam logic [6:0] CMD_REVISION  = 7'h20;
  localparam logic [6:0] CMD_IRQ_CLEAR = 7'h21;
  localparam logic [6:0] CMD_SOFT_RST  = 7'h22;
  localparam logic [6:0] CMD_HARD_RST  = 7'h23;
  localparam logic [6:0] CMD_MCLK_SEL  = 7'h24;
  localparam logic [6:0] CMD_CHAN_EN   = 7'h25;

  // Master clock selector codes.
  localparam logic [3:0] MCLK_8192 = 4'h0;
  localparam logic [3:0] MCLK_4096 = 4'h1;
  localparam logic [3:0] MCLK_2048 = 4'h2;
  localparam logic [3:0] MCLK_1536 = 4'h6;
  localparam logic [3:0] MCLK_1544 = 4'he;
  localparam logic [3:0] MCLK_3072 = 4'h5;
  localparam logic [3:0] MCLK_3088 = 4'hd;
  localparam logic [3:0] MCLK_6144 = 4'h4;
  localparam logic [3:0] MCLK_6176 = 4'hc;
  localparam logic [3:0] MCLK_SEL_RST = MCLK_2048;
  localparam logic [7:0] CHAN_EN_RST  = 8'h00;
  localparam logic [3:0] RSV_NIBBLE   = 4'h0;

  typedef enum logic [0:0] {
    CGC_ST_CMD  = 1'b0,
    CGC_ST_DATA = 1'b1
  } cgc_state_t;

  typedef struct packed {
    logic       write;
    logic [6:0] code;
    logic [7:0] data;
  } cgc_cmd_t;

  // Per-channel (local) settings; a one in standby means powered down.
  typedef struct packed {
    logic [N_CHAN-1:0]             standby;
    logic [N_CHAN-1:0]             loopback_en;
    logic [N_CHAN-1:0]             cutoff_en;
    logic [N_CHAN-1:0]             tx_pin_two;
    logic [N_CHAN-1:0]             rx_pin_two;
    logic [N_CHAN-1:0][SLOT_W-1:0] tx_slot;
    logic [N_CHAN-1:0][SLOT_W-1:0] rx_slot;
    logic [N_CHAN-1:0]             mu_law;
    logic [N_CHAN-1:0]             gain_not_0db;
    logic [N_CHAN-1:0]             coef_default;
    logic [N_CHAN-1:0]             impedance_en;
    logic [N_CHAN-1:0]             hybrid_en;
    logic [N_CHAN-1:0]             echo_en;
    logic [N_CHAN-1:0]             high_pass_en;
    logic [N_CHAN-1:0]             bidir_a_out;
    logic [N_CHAN-1:0]             bidir_b_out;
    logic [N_CHAN-1:0]             irq_en;
    logic [N_CHAN-1:0]             tone_on;
    logic [N_CHAN-1:0]             ring_trip_on;
    logic [N_CHAN-1:0]             meter_on;
  } cgc_local_cfg_t;

  typedef struct packed {
    logic [3:0]        mclk_sel;
    logic [N_CHAN-1:0] chan_prog_en;
    logic              gci_mode;
    logic              double_rate;
    logic              slot_pin;
    logic              tx_on_rise;
    logic              rx_on_fall;
    logic              debounce_a;
    logic              debounce_b;
    logic              fsk_on;
  } cgc_glob_cfg_t;

endpackage

/* File: rtl/cgc_reset_timer.sv */
// Qualifies the active-low reset pin: reports a pin reset once the pin
// has been low for the minimum reset time. Pin is synchronous to i_clk.
`timescale 1ns/100ps

module cgc_reset_timer
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_reset_pin_n,
  output logic      o_pin_reset
);

  logic [cgc_pkg::CNT_W-1:0] low_cnt_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_reset_pin_n)
      low_cnt_r <= '0;
    else if (low_cnt_r != cgc_pkg::RST_LOW_LAST)
      low_cnt_r <= low_cnt_r + 1'b1;
  end

  // Short glitches never reach the long count, so they cannot reset.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_pin_reset <= 1'b0;
    else
      o_pin_reset <= !i_reset_pin_n &&
                     (low_cnt_r == cgc_pkg::RST_LOW_LAST);
  end

endmodule

/* File: rtl/cgc_cmd_parser.sv */
// Splits the command byte stream into read requests and write
// command/data pairs. Bytes arrive already framed by the port logic.
`timescale 1ns/100ps

module cgc_cmd_parser
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_hold,
  input  wire logic             i_byte_valid,
  input  wire logic [7:0]       i_byte,
  output logic                  o_cmd_valid,
  output cgc_pkg::cgc_cmd_t     o_cmd
);

  cgc_pkg::cgc_state_t state_r;
  logic [6:0]          code_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_hold)
      state_r <= cgc_pkg::CGC_ST_CMD;
    else if (i_byte_valid)
    begin
      case (state_r)
        cgc_pkg::CGC_ST_CMD:
          if (i_byte[cgc_pkg::RW_BIT])
            state_r <= cgc_pkg::CGC_ST_DATA;
        cgc_pkg::CGC_ST_DATA:
          state_r <= cgc_pkg::CGC_ST_CMD;
        default:
          state_r <= cgc_pkg::CGC_ST_CMD;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      code_r <= '0;
    else if (i_byte_valid && state_r == cgc_pkg::CGC_ST_CMD)
      code_r <= i_byte[6:0];
  end

  // Writes are issued once the trailing data byte has arrived; reads
  // are issued on the command byte itself.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_hold)
    begin
      o_cmd_valid <= 1'b0;
      o_cmd       <= '0;
    end
    else
    begin
      o_cmd_valid <= i_byte_valid &&
                     (state_r == cgc_pkg::CGC_ST_DATA ||
                      !i_byte[cgc_pkg::RW_BIT]);
      o_cmd.write <= state_r == cgc_pkg::CGC_ST_DATA;
      o_cmd.code  <= (state_r == cgc_pkg::CGC_ST_DATA) ? code_r
                                                        : i_byte[6:0];
      o_cmd.data  <= i_byte;
    end
  end

endmodule

/* File: rtl/cgc_global_cmd.sv */
// Global command decoder and reset/default-state keeper of the
// eight-channel codec. Commands arrive as bytes from the host serial
// port or the monitor channel of the GCI link, in either mode.
// Assumes the reset pin and mode pins are synchronous to i_clk.
`timescale 1ns/100ps

module cgc_global_cmd
#(
  // Arbitrary neutral value; replace with the product revision.
  parameter logic [7:0] REVISION_NUMBER = 8'h0a
)
(
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_reset_pin_n,
  input  wire logic               i_gci_mode,
  input  wire logic               i_slot_select_pin,
  input  wire logic               i_double_rate_pin,
  input  wire logic               i_byte_valid,
  input  wire logic [7:0]         i_byte,
  output logic                    o_rsp_valid,
  output logic [7:0]              o_rsp_byte,
  output logic                    o_full_reset,
  output logic                    o_local_reset,
  output logic                    o_irq_clear,
  output logic                    o_chop_clk_one,
  output logic                    o_chop_clk_two,
  output cgc_pkg::cgc_local_cfg_t o_local_cfg,
  output cgc_pkg::cgc_glob_cfg_t  o_glob_cfg
);

  //////////////////////////////////////////////////////////////////////
  // Default values of the per-channel settings.

  function automatic cgc_pkg::cgc_local_cfg_t local_defaults();
    cgc_pkg::cgc_local_cfg_t d;
    d              = '0;
    d.standby      = '1;
    d.loopback_en  = '0;
    d.cutoff_en    = '0;
    d.tx_pin_two   = '0;
    d.rx_pin_two   = '0;
    for (int n = 0; n < cgc_pkg::N_CHAN; n++)
    begin
      d.tx_slot[n] = cgc_pkg::SLOT_W'(n);
      d.rx_slot[n] = cgc_pkg::SLOT_W'(n);
    end
    d.mu_law       = '0;
    d.gain_not_0db = '0;
    d.coef_default = '1;
    d.impedance_en = '0;
    d.hybrid_en    = '0;
    d.echo_en      = '0;
    d.high_pass_en = '1;
    d.bidir_a_out  = '0;
    d.bidir_b_out  = '0;
    d.irq_en       = '0;
    d.tone_on      = '0;
    d.ring_trip_on = '0;
    d.meter_on     = '0;
    return d;
  endfunction

  // The read/write bit of the command byte is never part of the match; all seven code bits are.
  function automatic logic is_cmd(input cgc_pkg::cgc_cmd_t c,
                                  input logic [6:0]        code);
    return c.code == code;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Reset pin qualification and command parsing.

  logic              pin_reset_w;
  logic              cmd_valid_w;
  cgc_pkg::cgc_cmd_t cmd_w;

  // The qualified reset lags the pin by the full minimum low time, so
  // brief dips never reset the configuration registers.
  cgc_reset_timer u_timer
  (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_reset_pin_n (i_reset_pin_n),
    .o_pin_reset   (pin_reset_w)
  );

  // Any low level on the pin returns the parser to its command state, qualified or not.
  cgc_cmd_parser u_parser
  (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_hold       (!i_reset_pin_n),
    .i_byte_valid (i_byte_valid),
    .i_byte       (i_byte),
    .o_cmd_valid  (cmd_valid_w),
    .o_cmd        (cmd_w)
  );

  //////////////////////////////////////////////////////////////////////
  // Reset sources.

  logic wr_w;
  logic rd_w;
  logic hard_cmd_w;
  logic soft_cmd_w;
  logic full_rst_w;
  logic local_rst_w;

  assign wr_w        = cmd_valid_w && cmd_w.write;
  assign rd_w        = cmd_valid_w && !cmd_w.write;
  assign hard_cmd_w  = wr_w && is_cmd(cmd_w, cgc_pkg::CMD_HARD_RST);
  assign soft_cmd_w  = wr_w && is_cmd(cmd_w, cgc_pkg::CMD_SOFT_RST);
  // The hard reset command is folded into the same path as the pin.
  assign full_rst_w  = i_rst || pin_reset_w || hard_cmd_w;
  assign local_rst_w = full_rst_w || soft_cmd_w;
  // A write whose data byte was taken before the pin fell still
  // executes; the pin drops bytes not yet taken, and a taken write command byte whose data byte is still to come.

  //////////////////////////////////////////////////////////////////////
  // Global registers: kept through a software reset.

  logic [3:0]                mclk_sel_r;
  logic [cgc_pkg::N_CHAN-1:0] chan_en_r;

  // The mode pin is looked at when a write executes, one edge after
  // its data byte, so a mode change with a write in flight decides
  // whether that write lands.

  always_ff @(posedge i_clk)
  begin
    if (full_rst_w)
      mclk_sel_r <= cgc_pkg::MCLK_SEL_RST;
    else if (wr_w && !i_gci_mode &&
             is_cmd(cmd_w, cgc_pkg::CMD_MCLK_SEL))
      mclk_sel_r <= cmd_w.data[3:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (full_rst_w)
      chan_en_r <= cgc_pkg::CHAN_EN_RST;
    else if (wr_w && !i_gci_mode &&
             is_cmd(cmd_w, cgc_pkg::CMD_CHAN_EN))
      chan_en_r <= cmd_w.data;
  end

  //////////////////////////////////////////////////////////////////////
  // Local registers: per-channel settings owned by other command
  // decoders; this block only forces their default state.

  always_ff @(posedge i_clk)
  begin
    if (local_rst_w)
      o_local_cfg <= local_defaults();
  end

  //////////////////////////////////////////////////////////////////////
  // Effective global configuration, one cycle behind the registers.

  cgc_pkg::cgc_glob_cfg_t glob_nxt;

  always_comb
  begin
    glob_nxt              = '0;
    glob_nxt.gci_mode     = i_gci_mode;
    glob_nxt.chan_prog_en = chan_en_r;
    glob_nxt.debounce_a   = 1'b0;
    glob_nxt.debounce_b   = 1'b0;
    glob_nxt.fsk_on       = 1'b0;
    if (i_gci_mode)
    begin
      // Clock and framing come from the link pins, not the registers.
      glob_nxt.mclk_sel    = i_double_rate_pin ? cgc_pkg::MCLK_4096
                                               : cgc_pkg::MCLK_2048;
      glob_nxt.double_rate = i_double_rate_pin;
      glob_nxt.slot_pin    = i_slot_select_pin;
      glob_nxt.tx_on_rise  = 1'b1;
      glob_nxt.rx_on_fall  = 1'b0;
    end
    else
    begin
      glob_nxt.mclk_sel    = mclk_sel_r;
      glob_nxt.double_rate = 1'b0;
      glob_nxt.slot_pin    = 1'b0;
      glob_nxt.tx_on_rise  = 1'b1;
      glob_nxt.rx_on_fall  = 1'b1;
    end
  end

  // During the power-on reset the whole carrier reads as zero; users
  // of it must wait for the reset to end before trusting any field.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_glob_cfg <= '0;
    else
      o_glob_cfg <= glob_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // Reset and interrupt pulses to the rest of the device. The
  // coefficient and FSK RAMs take none of these: their contents
  // survive every reset and vanish only with the supply.

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_full_reset  <= 1'b1;
      o_local_reset <= 1'b1;
      o_irq_clear   <= 1'b1;
    end
    else
    begin
      o_full_reset  <= full_rst_w;
      o_local_reset <= local_rst_w;
      o_irq_clear   <= full_rst_w || local_rst_w ||
                       (wr_w && is_cmd(cmd_w, cgc_pkg::CMD_IRQ_CLEAR));
    end
  end

  // The selection logic for the chopper clocks lives elsewhere; this
  // block parks both at a steady high on reset.
  always_ff @(posedge i_clk)
  begin
    if (full_rst_w)
    begin
      o_chop_clk_one <= 1'b1;
      o_chop_clk_two <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read answers. Write-only codes, host-only registers in GCI mode
  // and codes served by other decoders give no answer here. The no-op
  // write needs no branch: it matches nothing above.

  logic       rsp_hit_w;
  logic [7:0] rsp_data_w;

  always_comb
  begin
    rsp_hit_w  = 1'b0;
    rsp_data_w = '0;
    if (rd_w)
    begin
      if (is_cmd(cmd_w, cgc_pkg::CMD_REVISION))
      begin
        rsp_hit_w  = 1'b1;
        rsp_data_w = REVISION_NUMBER;
      end
      else if (!i_gci_mode && is_cmd(cmd_w, cgc_pkg::CMD_MCLK_SEL))
      begin
        rsp_hit_w  = 1'b1;
        rsp_data_w = {cgc_pkg::RSV_NIBBLE, mclk_sel_r};
      end
      else if (!i_gci_mode && is_cmd(cmd_w, cgc_pkg::CMD_CHAN_EN))
      begin
        rsp_hit_w  = 1'b1;
        rsp_data_w = chan_en_r;
      end
    end
  end

  // An answer that would fall while the pin is low is dropped rather
  // than delayed, so the host must ask again after releasing the pin.
  always_ff @(posedge i_clk)
  begin
    if (full_rst_w || !i_reset_pin_n)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_byte  <= '0;
    end
    else
    begin
      o_rsp_valid <= rsp_hit_w;
      o_rsp_byte  <= rsp_data_w;
    end
  end

endmodule

/* File: verif/cgc_global_chk.sv */
// Assertions on the ports of the global command and reset block.
// Assumes it is bound to every instance of cgc_global_cmd.
`timescale 1ns/100ps

module cgc_global_chk
#(
  parameter logic [7:0] REVISION_NUMBER = 8'h0a
)
(
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  input wire logic                    i_reset_pin_n,
  input wire logic                    i_gci_mode,
  input wire logic                    i_byte_valid,
  input wire logic [7:0]              i_byte,
  input wire logic                    o_rsp_valid,
  input wire logic [7:0]              o_rsp_byte,
  input wire logic                    o_full_reset,
  input wire logic                    o_local_reset,
  input wire logic                    o_irq_clear,
  input wire logic                    o_chop_clk_one,
  input wire logic                    o_chop_clk_two,
  input wire cgc_pkg::cgc_local_cfg_t o_local_cfg,
  input wire cgc_pkg::cgc_glob_cfg_t  o_glob_cfg
);
  logic [11:0] low_cnt_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Saturates so that a very long low pin cannot wrap back to zero.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_reset_pin_n)
      low_cnt_r <= 12'h000;
    else if (low_cnt_r != 12'hfff)
      low_cnt_r <= low_cnt_r + 12'h001;
  end

  a_pin_long_low: assert property (
    low_cnt_r >= 12'h4e3 |-> o_full_reset)
    else $error("Long low reset pin without full reset");
  a_reset_defaults: assert property (
    o_full_reset |=> o_local_cfg.standby == 8'hff && o_chop_clk_one
      && o_chop_clk_two && o_local_cfg.high_pass_en == 8'hff
      && o_local_cfg.loopback_en == 8'h00 && o_local_cfg.tx_pin_two == 8'h00)
    else $error("Defaults missing after full reset");
  a_reset_strobes: assert property (
    o_full_reset |-> o_local_reset && o_irq_clear)
    else $error("Full reset without local reset or irq clear");
  a_mclk_default: assert property (
    o_full_reset && !i_gci_mode |=> ##1 o_glob_cfg.mclk_sel == 4'h2
      && o_glob_cfg.chan_prog_en == 8'h00)
    else $error("Clock select or enables not default after reset");
  a_irq_clear_cmd: assert property (
    (i_reset_pin_n && i_byte_valid && i_byte == 8'ha1) ##1
    (i_reset_pin_n && i_byte_valid && i_byte == 8'hff)
      |-> ##2 o_irq_clear && !o_full_reset && !o_local_reset)
    else $error("Interrupt clear command misbehaved");
  a_soft_reset_cmd: assert property (
    (i_reset_pin_n && i_byte_valid && i_byte == 8'ha2) ##1
    (i_reset_pin_n && i_byte_valid && i_byte == 8'hff)
      |-> ##2 o_local_reset && !o_full_reset)
    else $error("Soft reset command misbehaved");
  a_hard_reset_cmd: assert property (
    (i_reset_pin_n && i_byte_valid && i_byte == 8'ha3) ##1
    (i_reset_pin_n && i_byte_valid && i_byte == 8'hff) |-> ##2 o_full_reset)
    else $error("Hard reset command gave no full reset");
  a_rsp_from_read: assert property (
    o_rsp_valid |-> $past(i_byte_valid, 2) && $past(i_byte, 2) < 8'h80
      && $past(i_reset_pin_n, 2))
    else $error("Answer without an accepted read command");
  a_revision_read: assert property (
    o_rsp_valid && $past(i_byte, 2) == 8'h20 |-> o_rsp_byte == REVISION_NUMBER)
    else $error("Wrong revision answer");
  a_mclk_read: assert property (
    o_rsp_valid && $past(i_byte, 2) == 8'h24 |-> !$past(i_gci_mode, 2)
      && o_rsp_byte == {4'h0, o_glob_cfg.mclk_sel})
    else $error("Wrong clock select answer");
  a_chan_read: assert property (
    o_rsp_valid && $past(i_byte, 2) == 8'h25 |-> !$past(i_gci_mode, 2)
      && o_rsp_byte == o_glob_cfg.chan_prog_en)
    else $error("Wrong channel enable answer");
endmodule

bind cgc_global_cmd cgc_global_chk #(.REVISION_NUMBER(REVISION_NUMBER)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_reset_pin_n(i_reset_pin_n),
  .i_gci_mode(i_gci_mode), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
  .o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte),
  .o_full_reset(o_full_reset), .o_local_reset(o_local_reset),
  .o_irq_clear(o_irq_clear), .o_chop_clk_one(o_chop_clk_one),
  .o_chop_clk_two(o_chop_clk_two), .o_local_cfg(o_local_cfg),
  .o_glob_cfg(o_glob_cfg));

/* File: verif/cgc_host_model.sv */
// Host model: sends command and data bytes and collects answers.
// Assumes an answer stands two cycles after its command byte.
`timescale 1ns/100ps

module cgc_host_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rsp_valid,
  input  wire logic [7:0] i_rsp_byte,
  output logic            o_byte_valid,
  output logic [7:0]      o_byte
);
  initial
  begin
    o_byte_valid = 1'b0;
    o_byte       = 8'h00;
  end

  task automatic put(input logic [7:0] b);
    @(negedge i_clk);
    o_byte_valid = 1'b1;
    o_byte       = b;
  endtask

  // Each idle cycle inverts the byte on the bus, so the first idle after a
  // byte shows its inverse and a stale copy cannot pass for a fresh one.
  task automatic idle();
    @(negedge i_clk);
    o_byte_valid = 1'b0;
    o_byte       = ~o_byte;
  endtask

  task automatic wr(input logic [6:0] c, input logic [7:0] d, input int gap);
    put({1'b1, c});
    repeat (gap) idle();
    if (c inside {7'h20, 7'h21, 7'h22, 7'h23})
      put(8'hff);
    else if (c == 7'h24)
      put({4'h0, d[3:0]});
    else
      put(d);
    idle();
  endtask

  task automatic rd(input logic [6:0] c, output logic ok,
                    output logic [7:0] d);
    put({1'b0, c});
    idle();
    @(negedge i_clk);
    ok = i_rsp_valid;
    d  = i_rsp_byte;
  endtask
endmodule

/* File: verif/test_cgc_global_cmd.sv */
// Self-checking bench of the global command and reset block.
// Assumes the host model drives bytes and the checker is bound.
`timescale 1ns/100ps

`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s expected %h seen %h", n, e, g); end end

module test_cgc_global_cmd;
  localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value.
  logic                    i_clk = 1'b0;
  logic                    i_rst = 1'b1;
  logic                    pin_n = 1'b1, gci = 1'b0, slot = 1'b0;
  logic                    dbl = 1'b0, sf = 1'b0, sl = 1'b0, si = 1'b0;
  logic                    bv, rv, full, loc, irq, ch1, ch2, ok;
  logic [7:0]              bt, rb, got;
  cgc_pkg::cgc_local_cfg_t lc, exp_lc;
  cgc_pkg::cgc_glob_cfg_t  gc;
  int                      mismatches = 0, total_checks = 0;
  logic [3:0]              codes [9] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'he,
                                         4'h5, 4'hd, 4'h4, 4'hc};

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    sf <= sf | (full === 1'b1);
    sl <= sl | (loc === 1'b1);
    si <= si | (irq === 1'b1);
  end

  cgc_host_model host (.i_clk(i_clk), .i_rsp_valid(rv), .i_rsp_byte(rb),
    .o_byte_valid(bv), .o_byte(bt));
  cgc_global_cmd #(.REVISION_NUMBER(REV)) DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_reset_pin_n(pin_n), .i_gci_mode(gci), .i_slot_select_pin(slot),
    .i_double_rate_pin(dbl), .i_byte_valid(bv), .i_byte(bt),
    .o_rsp_valid(rv), .o_rsp_byte(rb), .o_full_reset(full),
    .o_local_reset(loc), .o_irq_clear(irq), .o_chop_clk_one(ch1),
    .o_chop_clk_two(ch2), .o_local_cfg(lc), .o_glob_cfg(gc));

  ////////////////////////////////////////////////////////////////////////
  task automatic go(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic clr();
    sf = 1'b0;
    sl = 1'b0;
    si = 1'b0;
  endtask

  task automatic chk_rd(input logic [6:0] c, input logic [7:0] e);
    host.rd(c, ok, got);
    `CHK("answer strobe", 1'b1, ok)
    `CHK("answer byte", e, got)
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    final_report();
  end

  initial
  begin
    exp_lc = '0;
    exp_lc.standby = 8'hff;
    exp_lc.coef_default = 8'hff;
    exp_lc.high_pass_en = 8'hff;
    for (int n = 0; n < 8; n++)
    begin
      exp_lc.tx_slot[n] = 7'(n);
      exp_lc.rx_slot[n] = 7'(n);
    end
    go(6);
    i_rst = 1'b0;
    go(3);
    `CHK("local cfg", exp_lc, lc)
    `CHK("chopper", 2'b11, {ch1, ch2})
    `CHK("mclk", 4'h2, gc.mclk_sel)
    `CHK("tx edge", 1'b1, gc.tx_on_rise)
    `CHK("rx edge rate", 2'b10, {gc.rx_on_fall, gc.double_rate})
    `CHK("debounce", 2'b00, {gc.debounce_a, gc.debounce_b})
    `CHK("fsk", 1'b0, gc.fsk_on)
    chk_rd(7'h20, REV);
    foreach (codes[k])
    begin
      host.wr(7'h24, {4'hf, codes[k]}, 0);
      chk_rd(7'h24, {4'h0, codes[k]});
      `CHK("mclk", codes[k], gc.mclk_sel)
    end
    host.wr(7'h25, 8'h5a, 3);
    chk_rd(7'h25, 8'h5a);
    `CHK("enables", 8'h5a, gc.chan_prog_en)
    clr();
    host.wr(7'h20, 8'h00, 0);
    go(4);
    `CHK("strobes", 3'b000, {sf, sl, si})
    chk_rd(7'h24, 8'h0c);
    clr();
    host.wr(7'h21, 8'h00, 0);
    go(4);
    `CHK("strobes", 3'b001, {sf, sl, si})
    clr();
    host.wr(7'h22, 8'h00, 0);
    go(4);
    `CHK("strobes", 3'b011, {sf, sl, si})
    `CHK("local cfg", exp_lc, lc)
    chk_rd(7'h25, 8'h5a);
    chk_rd(7'h24, 8'h0c);
    clr();
    host.wr(7'h23, 8'h00, 0);
    go(6);
    `CHK("full reset", 1'b1, sf)
    chk_rd(7'h24, 8'h02);
    chk_rd(7'h25, 8'h00);
    host.wr(7'h24, 8'h01, 0);
    clr();
    pin_n = 1'b0;
    host.wr(7'h24, 8'h05, 0);
    host.rd(7'h20, ok, got);
    `CHK("answer while low", 1'b0, ok)
    go(50);
    pin_n = 1'b1;
    go(3);
    `CHK("short low", 1'b0, sf)
    chk_rd(7'h24, 8'h01);
    pin_n = 1'b0;
    go(1300);
    `CHK("long low", 1'b1, sf)
    pin_n = 1'b1;
    go(3);
    chk_rd(7'h24, 8'h02);
    gci = 1'b1;
    slot = 1'b1;
    go(4);
    `CHK("gci mclk", 4'h2, gc.mclk_sel)
    `CHK("gci mode slot", 2'b11, {gc.gci_mode, gc.slot_pin})
    `CHK("gci edges", 2'b10, {gc.tx_on_rise, gc.rx_on_fall})
    dbl = 1'b1;
    go(4);
    `CHK("gci mclk", 4'h1, gc.mclk_sel)
    `CHK("gci rate", 1'b1, gc.double_rate)
    host.rd(7'h24, ok, got);
    `CHK("gci read", 1'b0, ok)
    host.wr(7'h25, 8'hff, 0);
    go(2);
    gci = 1'b0;
    dbl = 1'b0;
    go(3);
    chk_rd(7'h25, 8'h00);
    host.rd(7'h21, ok, got);
    `CHK("write-only read", 1'b0, ok)
    host.wr(7'h24, 8'h06, 0);
    chk_rd(7'h24, 8'h06);
    i_rst = 1'b1;
    go(2);
    i_rst = 1'b0;
    go(3);
    `CHK("local cfg", exp_lc, lc)
    chk_rd(7'h24, 8'h02);
    final_report();
  end
endmodule
